// ===== common/cfs_pkg.sv
package cfs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 13;
  localparam int NVM_IDX_W = 7;

  // Shared low window and the recalled configuration region.
  localparam logic [ADDR_W-1:0] SHARED_LAST = 8'h57;
  localparam logic [ADDR_W-1:0] CFG_LAST = 8'h4b;
  localparam int NVM_WORDS = 88;
  localparam int CFG_WORDS = 76;

  // Access select control byte and its bit.
  localparam logic [ADDR_W-1:0] SEL_ADDR = 8'h89;
  localparam int SEL_BIT = 0;
  localparam logic SEL_RESET = 1'b0;

  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;

  // Internal array write cycle.
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned WRITE_TIME_MS = 30;
  localparam int unsigned WRITE_CYCLES_DEF =
    WRITE_TIME_MS * (CLK_FREQ_HZ / 1000);

  localparam int unsigned RECALL_TRIES_DEF = 2;

  typedef enum logic [1:0] {
    ST_RECALL = 2'b00,
    ST_RUN = 2'b01,
    ST_WRITE = 2'b11,
    ST_PWRDN = 2'b10
  } cfs_state_t;

endpackage

// ===== rtl/cfs_secded.sv
`timescale 1ns/10ps
module cfs_secded (
  input wire logic [cfs_pkg::DATA_W-1:0] enc_data_i,
  output logic [cfs_pkg::CODE_W-1:0] enc_code_o,
  input wire logic [cfs_pkg::CODE_W-1:0] dec_code_i,
  output logic [cfs_pkg::DATA_W-1:0] dec_data_o,
  output logic dec_single_o,
  output logic dec_double_o
);
  import cfs_pkg::*;

  logic [12:1] eh;
  logic [12:1] dg;
  logic [3:0] syn;
  logic ovr;
  int ek;
  int dk;

  // Hamming positions 1..12 carry data where not a power of two; bit 0 is
  // the overall parity that turns single correction into double detection.
  always_comb begin
    eh = '0;
    ek = 0;
    for (int p = 1; p <= 12; p++) begin
      if ((p & (p - 1)) != 0) begin
        eh[p] = enc_data_i[ek];
        ek = ek + 1;
      end
    end
    for (int j = 0; j < 4; j++) begin
      for (int p = 1; p <= 12; p++) begin
        if (((p >> j) & 1) == 1 && p != (1 << j)) begin
          eh[1 << j] = eh[1 << j] ^ eh[p];
        end
      end
    end
    enc_code_o = {eh, ^eh};
  end

  always_comb begin
    dg = dec_code_i[CODE_W-1:1];
    syn = '0;
    for (int j = 0; j < 4; j++) begin
      for (int p = 1; p <= 12; p++) begin
        if (((p >> j) & 1) == 1) begin
          syn[j] = syn[j] ^ dg[p];
        end
      end
    end
    ovr = ^dec_code_i;
    dec_single_o = ovr && (syn <= 4'd12);
    dec_double_o = (!ovr && syn != 4'd0) || (ovr && syn > 4'd12);
    if (dec_single_o && syn != 4'd0) begin
      dg[syn] = ~dg[syn];
    end
    dec_data_o = '0;
    dk = 0;
    for (int p = 1; p <= 12; p++) begin
      if ((p & (p - 1)) != 0) begin
        dec_data_o[dk] = dg[p];
        dk = dk + 1;
      end
    end
  end

endmodule

// ===== rtl/cfs_shadow_top.sv
`timescale 1ns/10ps
module cfs_shadow_top #(
  parameter int unsigned WRITE_CYCLES = cfs_pkg::WRITE_CYCLES_DEF,
  parameter int unsigned RECALL_TRIES = cfs_pkg::RECALL_TRIES_DEF
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic powerdown_i,
  input wire logic host_req_i,
  input wire logic host_wr_i,
  input wire logic [cfs_pkg::ADDR_W-1:0] host_addr_i,
  input wire logic [cfs_pkg::DATA_W-1:0] host_wdata_i,
  output logic host_ack_o,
  output logic [cfs_pkg::DATA_W-1:0] host_rdata_o,
  output logic host_busy_o,
  output logic host_drive_en_o,
  input wire logic nvm_prog_we_i,
  input wire logic [cfs_pkg::ADDR_W-1:0] nvm_prog_addr_i,
  input wire logic [cfs_pkg::CODE_W-1:0] nvm_prog_code_i,
  output logic nvm_sel_o,
  output logic ecc_used_o,
  output logic ecc_fail_o,
  output logic run_en_o,
  output logic recall_fail_o,
  output logic [cfs_pkg::CFG_WORDS*cfs_pkg::DATA_W-1:0] cfg_flat_o
);
  import cfs_pkg::*;

  function automatic logic in_shared(input logic [ADDR_W-1:0] a);
    return a <= SHARED_LAST;
  endfunction

  function automatic logic in_cfg(input logic [ADDR_W-1:0] a);
    return a <= CFG_LAST;
  endfunction

  cfs_state_t state_q;
  logic [CODE_W-1:0] nvm_q [NVM_WORDS];
  logic [DATA_W-1:0] cfg_q [CFG_WORDS];
  logic nvm_sel_q;
  logic [ADDR_W-1:0] rc_idx_q;
  logic [7:0] tries_q;
  logic rc_fail_q;
  logic recall_fail_q;
  logic run_q;
  logic [31:0] wc_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wr_data_q;
  logic ecc_used_q;
  logic ecc_fail_q;
  logic ack_q;
  logic [DATA_W-1:0] rdata_q;

  logic acc;
  logic nvm_acc;
  logic cfg_acc;
  logic sel_acc;
  logic array_rd;
  logic [ADDR_W-1:0] rd_idx;
  logic [CODE_W-1:0] rd_code;
  logic [CODE_W-1:0] enc_code;
  logic [DATA_W-1:0] dec_data;
  logic dec_single;
  logic dec_double;
  logic rc_last;
  logic rc_fail_now;
  logic rc_retry;
  logic rc_done;
  logic wc_last;

  // Requests count only in normal operation; a write cycle, a recall or
  // powerdown leaves the host unanswered.
  always_comb begin
    acc = (state_q == ST_RUN) && host_req_i && !powerdown_i;
    nvm_acc = acc && nvm_sel_q && in_shared(host_addr_i);
    cfg_acc = acc && !nvm_sel_q && in_cfg(host_addr_i);
    sel_acc = acc && (host_addr_i == SEL_ADDR);
    array_rd = (state_q == ST_RECALL) || (nvm_acc && !host_wr_i);
  end

  always_comb begin
    if (state_q == ST_RECALL) begin
      rd_idx = rc_idx_q;
    end else begin
      rd_idx = host_addr_i;
    end
    if (in_shared(rd_idx)) begin
      rd_code = nvm_q[rd_idx[NVM_IDX_W-1:0]];
    end else begin
      rd_code = '0;
    end
  end

  cfs_secded u_codec (
    .enc_data_i(wr_data_q),
    .enc_code_o(enc_code),
    .dec_code_i(rd_code),
    .dec_data_o(dec_data),
    .dec_single_o(dec_single),
    .dec_double_o(dec_double)
  );

  // A pass that saw an uncorrectable word is repeated while tries remain.
  always_comb begin
    rc_last = (rc_idx_q == ADDR_W'(CFG_WORDS - 1));
    rc_fail_now = rc_fail_q || dec_double;
    rc_retry = rc_fail_now && (32'(tries_q) + 32'd1 < RECALL_TRIES);
    rc_done = (state_q == ST_RECALL) && rc_last && !rc_retry;
    wc_last = (wc_q == WRITE_CYCLES - 32'd1);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_RECALL;
    end else if (powerdown_i) begin
      state_q <= ST_PWRDN;
    end else begin
      case (state_q)
        ST_RECALL: begin
          if (rc_done) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (nvm_acc && host_wr_i) begin
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (wc_last) begin
            state_q <= ST_RUN;
          end
        end
        ST_PWRDN: begin
          state_q <= ST_RECALL;
        end
        default: begin
          state_q <= ST_RECALL;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rc_idx_q <= '0;
    end else if (powerdown_i || state_q != ST_RECALL || rc_last) begin
      rc_idx_q <= '0;
    end else begin
      rc_idx_q <= rc_idx_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tries_q <= '0;
      rc_fail_q <= 1'b0;
    end else if (powerdown_i || state_q != ST_RECALL) begin
      tries_q <= '0;
      rc_fail_q <= 1'b0;
    end else if (rc_last) begin
      tries_q <= tries_q + 8'h01;
      rc_fail_q <= 1'b0;
    end else begin
      rc_fail_q <= rc_fail_now;
    end
  end

  // Operation is released only once a recall pass has been checked.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_q <= 1'b0;
      recall_fail_q <= 1'b0;
    end else if (powerdown_i) begin
      run_q <= 1'b0;
      recall_fail_q <= 1'b0;
    end else if (rc_done) begin
      run_q <= 1'b1;
      recall_fail_q <= rc_fail_now;
    end
  end

  // The working copy is the only source of device behaviour; array writes
  // never reach it outside a recall.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
    end else if (powerdown_i) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
    end else if (state_q == ST_RECALL) begin
      if (!dec_double) begin
        cfg_q[rc_idx_q[NVM_IDX_W-1:0]] <= dec_data;
      end
    end else if (cfg_acc && host_wr_i) begin
      cfg_q[host_addr_i[NVM_IDX_W-1:0]] <= host_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nvm_sel_q <= SEL_RESET;
    end else if (powerdown_i) begin
      nvm_sel_q <= SEL_RESET;
    end else if (sel_acc && host_wr_i) begin
      nvm_sel_q <= host_wdata_i[SEL_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else if (nvm_acc && host_wr_i) begin
      wr_addr_q <= host_addr_i;
      wr_data_q <= host_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wc_q <= '0;
    end else if (state_q != ST_WRITE) begin
      wc_q <= '0;
    end else begin
      wc_q <= wc_q + 32'd1;
    end
  end

  // The array has no reset: it keeps its contents across every reset.
  // The byte is committed at the end of the write cycle, and an aborted
  // cycle (powerdown) leaves the old word in place.
  always_ff @(posedge core_clk_i) begin
    if (nvm_prog_we_i && in_shared(nvm_prog_addr_i)) begin
      nvm_q[nvm_prog_addr_i[NVM_IDX_W-1:0]] <= nvm_prog_code_i;
    end else if (state_q == ST_WRITE && wc_last && !powerdown_i) begin
      nvm_q[wr_addr_q[NVM_IDX_W-1:0]] <= enc_code;
    end
  end

  // Every array read, recall words included, overwrites both flags.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ecc_used_q <= 1'b0;
      ecc_fail_q <= 1'b0;
    end else if (array_rd) begin
      ecc_used_q <= dec_single;
      ecc_fail_q <= dec_double;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= acc;
      if (acc && !host_wr_i) begin
        if (nvm_acc) begin
          rdata_q <= dec_data;
        end else if (cfg_acc) begin
          rdata_q <= cfg_q[host_addr_i[NVM_IDX_W-1:0]];
        end else if (sel_acc) begin
          rdata_q <= {7'h00, nvm_sel_q};
        end else begin
          rdata_q <= '0;
        end
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CFG_WORDS; gi++) begin : g_cfg
      assign cfg_flat_o[gi*DATA_W +: DATA_W] = cfg_q[gi];
    end
  endgenerate

  assign host_ack_o = ack_q;
  assign host_rdata_o = rdata_q;
  assign host_busy_o = (state_q != ST_RUN);
  assign host_drive_en_o = (state_q == ST_RUN);
  assign nvm_sel_o = nvm_sel_q;
  assign ecc_used_o = ecc_used_q;
  assign ecc_fail_o = ecc_fail_q;
  assign run_en_o = run_q;
  assign recall_fail_o = recall_fail_q;

endmodule

// ===== tb/cfs_shadow_chk.sv
`timescale 1ns/10ps
module cfs_shadow_chk #(
  parameter int WRITE_CYCLES = 8
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic powerdown_i,
  input wire logic host_req_i,
  input wire logic host_wr_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic host_ack_o,
  input wire logic host_busy_o,
  input wire logic nvm_sel_o,
  input wire logic ecc_used_o,
  input wire logic ecc_fail_o,
  input wire logic [607:0] cfg_flat_o
);
  localparam int WC_M1 = WRITE_CYCLES - 1;
  wire tk = host_req_i && !host_busy_o && !powerdown_i;
  wire wr_sel = tk && host_wr_i && host_addr_i == 8'h89;
  wire wr_nvm = tk && host_wr_i && nvm_sel_o && host_addr_i <= 8'h57;
  wire wr_cfg = tk && host_wr_i && !nvm_sel_o && host_addr_i <= 8'h4b;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_ack_taken:
    assert property (tk |=> host_ack_o) else $error("ack missing");
  a_ack_refused:
    assert property (!tk |=> !host_ack_o) else $error("stray ack");
  a_write_cycle_len:
    assert property (disable iff (!resetn_i || powerdown_i) wr_nvm |=>
      (host_busy_o throughout (1'b1 ##WC_M1 1'b1)) ##1 !host_busy_o)
      else $error("write cycle length wrong");
  a_nvm_cfg_kept:
    assert property (disable iff (!resetn_i || powerdown_i)
      wr_nvm |=> $stable(cfg_flat_o) [*8]) else $error("cfg changed");
  a_cfg_write_now:
    assert property (wr_cfg |=> cfg_flat_o[{$past(host_addr_i), 3'b000}
      +: 8] == $past(host_wdata_i)) else $error("cfg write lost");
  a_sel_hold:
    assert property (!wr_sel && !powerdown_i |=> $stable(nvm_sel_o))
      else $error("select changed");
  a_sel_write:
    assert property (wr_sel |=> nvm_sel_o == $past(host_wdata_i[0]))
      else $error("select not written");
  a_pd_clear:
    assert property (powerdown_i |=> host_busy_o && !nvm_sel_o
      && cfg_flat_o == '0) else $error("powerdown kept state");
  a_flags_excl:
    assert property (!(ecc_used_o && ecc_fail_o)) else $error("both flags");
endmodule

// ===== tb/cfs_host_model.sv
`timescale 1ns/10ps
module cfs_host_model (
  input wire logic core_clk_i,
  input wire logic host_ack_i,
  input wire logic host_busy_i,
  input wire logic [7:0] host_rdata_i,
  output logic host_req_o,
  output logic host_wr_o,
  output logic [7:0] host_addr_o,
  output logic [7:0] host_wdata_o
);
  initial {host_req_o, host_wr_o, host_addr_o, host_wdata_o} = '0;
  // One byte per transaction, never a page burst.
  task automatic xfer(input logic w, input logic [7:0] a, d,
      output logic [7:0] q, output logic k);
    @(posedge core_clk_i);
    host_req_o <= 1'b1;
    host_wr_o <= w;
    host_addr_o <= a;
    host_wdata_o <= d;
    @(posedge core_clk_i);
    host_req_o <= 1'b0;
    host_addr_o <= ~a;
    host_wdata_o <= ~d;
    #1;
    q = host_rdata_i;
    k = host_ack_i;
  endtask
  // The first byte of a page is read twice.
  task automatic rd(input logic [7:0] a, output logic [7:0] q,
      output logic k);
    if (a[1:0] == 2'b00) xfer(1'b0, a, 8'h00, q, k);
    xfer(1'b0, a, 8'h00, q, k);
  endtask
  // Waits until the device listens again.
  task automatic idle(output logic k);
    k = 1'b0;
    for (int n = 0; n < 5000 && !k; n++) begin
      @(posedge core_clk_i);
      #1;
      k = host_busy_i === 1'b0;
    end
  endtask
endmodule

// ===== tb/cfs_shadow_tb_top.sv
`timescale 1ns/10ps
module cfs_shadow_tb_top;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic powerdown_i = 1'b0;
  logic pwe = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [12:0] pc = 13'h0000;
  logic req, wr, ack, busy, den, sel, used, fail, run, rfail, k;
  logic [7:0] addr, wd, rdat, q, d;
  logic [607:0] cfg;
  logic [31:0] seed = 32'hc0f6;
  logic [7:0] mem [88];
  logic [7:0] shd [76];
  logic [7:0] t [5] = '{8'h00, 8'h02, 8'h05, 8'h10, 8'h50};
  int failures = 0;
  int total_checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  cfs_shadow_top #(.WRITE_CYCLES(8), .RECALL_TRIES(2)) dut_u (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .powerdown_i(powerdown_i), .host_req_i(req), .host_wr_i(wr),
    .host_addr_i(addr), .host_wdata_i(wd), .host_ack_o(ack),
    .host_rdata_o(rdat), .host_busy_o(busy), .host_drive_en_o(den),
    .nvm_prog_we_i(pwe), .nvm_prog_addr_i(pa), .nvm_prog_code_i(pc),
    .nvm_sel_o(sel), .ecc_used_o(used), .ecc_fail_o(fail),
    .run_en_o(run), .recall_fail_o(rfail), .cfg_flat_o(cfg));
  cfs_host_model host_u (.core_clk_i(core_clk_i), .host_ack_i(ack),
    .host_busy_i(busy), .host_rdata_i(rdat), .host_req_o(req),
    .host_wr_o(wr), .host_addr_o(addr), .host_wdata_o(wd));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Hamming positions 12..1 plus overall even parity in bit 0.
  function automatic logic [12:0] enc(input logic [7:0] v);
    logic [12:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 3; p < 13; p++) begin
      if (p != 4 && p != 8) begin
        c[p] = v[j];
        j++;
      end
    end
    for (int b = 1; b < 9; b = b * 2) begin
      for (int p = 3; p < 13; p++) begin
        if ((p & b) != 0 && p != b) c[b] ^= c[p];
      end
    end
    c[0] = ^c[12:1];
    return c;
  endfunction
  task automatic chk(input string n, input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic boot();
    foreach (shd[i]) shd[i] = (i == 5) ? 8'h00 : mem[i];
    host_u.idle(k);
    chk("start", {k, run, rfail, used, fail}, 5'b11100);
    foreach (shd[i]) chk("cfg", cfg[8*i +: 8], shd[i]);
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 88; i++) begin
      mem[i] = rnd();
      @(posedge core_clk_i);
      pwe <= 1'b1;
      pa <= 8'(i);
      pc <= enc(mem[i]) ^ (i == 2 ? 13'h0040 : 13'h0)
        ^ (i == 5 ? 13'h0300 : 13'h0);
    end
    @(posedge core_clk_i);
    pwe <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    boot();
    $display("recall test done");
    host_u.rd(8'h89, q, k);
    chk("sel_rd", {k, sel, q}, 10'h200);
    d = rnd();
    host_u.xfer(1'b1, 8'h10, d, q, k);
    chk("cfg_wr", cfg[135:128], d);
    shd[16] = d;
    host_u.rd(8'h4c, q, k);
    chk("no_shadow", q, 8'h00);
    host_u.xfer(1'b1, 8'h89, 8'h01, q, k);
    chk("sel_set", sel, 1'b1);
    foreach (t[j]) begin
      host_u.rd(t[j], q, k);
      if (t[j] == 8'h05) q = 8'h00;
      else q = q ^ mem[t[j]];
      chk("nvm", {used, fail, q}, {t[j]==2, t[j]==5, 8'h0});
    end
    $display("access test done");
    d = rnd();
    host_u.xfer(1'b1, 8'h10, d, q, k);
    mem[16] = d;
    host_u.xfer(1'b0, 8'h00, 8'h00, q, k);
    chk("refused", {k, den, busy}, 3'b001);
    host_u.idle(k);
    chk("cfg_kept", {k, cfg[135:128]}, {1'b1, shd[16]});
    host_u.rd(8'h10, q, k);
    chk("nvm_new", q, mem[16]);
    host_u.xfer(1'b1, 8'h89, 8'h00, q, k);
    host_u.rd(8'h10, q, k);
    chk("sel_clr", {sel, q}, {1'b0, shd[16]});
    $display("write test done");
    host_u.xfer(1'b1, 8'h89, 8'h01, q, k);
    chk("pd_sel", sel, 1'b1);
    @(posedge core_clk_i);
    powerdown_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("pd", {run, busy, sel, |cfg}, 4'b0100);
    @(posedge core_clk_i);
    powerdown_i <= 1'b0;
    boot();
    $display("powerdown test done");
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    close_out();
  end
endmodule
bind cfs_shadow_top cfs_shadow_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i),
  .powerdown_i(powerdown_i), .host_req_i(host_req_i),
  .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
  .host_wdata_i(host_wdata_i), .host_ack_o(host_ack_o),
  .host_busy_o(host_busy_o), .nvm_sel_o(nvm_sel_o),
  .ecc_used_o(ecc_used_o), .ecc_fail_o(ecc_fail_o),
  .cfg_flat_o(cfg_flat_o));
